// ==== logic/mode_select_field_pkg.sv ====
package mode_select_field_pkg;

  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAILSAFE
  } mode_select_field_type;

  // serial frame layout: [15:8] data, [7] write, [6:0] address
  localparam int          FRAME_BITS     = 16;
  localparam int          WRITE_BIT      = 7;
  localparam int          DATA_LSB       = 8;
  localparam logic [6:0]  MODE_CTRL_ADDR = 7'h01;
  localparam logic [6:0]  HW_CTRL_ADDR   = 7'h02;
  localparam logic [6:0]  WATCHDOG_CONTROL_REG_ADDR   = 7'h03;

  // mode control register, mode select field in data[1:0]
  localparam logic [1:0]  MSEL_NORMAL    = 2'h0;
  localparam logic [1:0]  MSEL_SLEEP     = 2'h1;
  localparam logic [1:0]  MSEL_STOP      = 2'h2;
  localparam logic [1:0]  MSEL_SOFT_RST  = 2'h3;
  localparam logic [1:0]  MSEL_RESET_VAL = 2'h0;

  // hardware control register bits
  localparam int          HW_FAIL_CNT_BIT = 2;
  localparam int          HW_OV_RST_BIT   = 1;
  localparam int          HW_POR_CLR_BIT  = 0;
  localparam logic        FAIL_CNT_RESET  = 1'b0;
  localparam logic        OV_RST_RESET    = 1'b0;

  // watchdog control register bits
  localparam int          WD_LIMIT3_BIT   = 0;
  localparam logic [1:0]  MAX_WD_RESETS   = 2'h3;
  localparam logic [1:0]  WD_FAIL_SAT     = 2'h2;

  // timing
  localparam int          CLK_MHZ         = 100;
  localparam int          RESET_DELAY_US  = 10;
  localparam int          RESET_DELAY_CYC = RESET_DELAY_US * CLK_MHZ;
  localparam int          CFG_FILT_NS     = 500;
  localparam int          CFG_FILT_CYC    = (CFG_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int          LONG_WINDOW_MS  = 200;
  localparam int          LONG_WINDOW_CYC = LONG_WINDOW_MS * 1000 * CLK_MHZ;
  localparam int          WD_CNT_W        = 25;
  localparam int          RD_CNT_W        = 11;
  localparam int          FILT_CNT_W      = 7;

  // synchronised pin vector positions
  localparam int          PIN_IO_OK    = 0;
  localparam int          PIN_VS_SHORT = 1;
  localparam int          PIN_IO_OV    = 2;
  localparam int          PIN_WAKE     = 3;
  localparam int          PIN_TEST     = 4;
  localparam int          PIN_INTR     = 5;
  localparam int          PIN_TSD      = 6;
  localparam int          PIN_COUNT    = 7;

endpackage

// ==== logic/mode_select_field_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none

module mode_select_field_ctrl #(
  parameter int unsigned LONG_WINDOW_CYC = mode_select_field_pkg::LONG_WINDOW_CYC
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        spi_clk,
  input  wire logic                        spi_cs_n,
  input  wire logic                        spi_mosi,
  input  wire logic                        io_supply_ok,
  input  wire logic                        vs_above_short,
  input  wire logic                        io_overvoltage,
  input  wire logic                        wake_in,
  input  wire logic                        test_pin,
  input  wire logic                        thermal_shutdown_two,
  input  wire logic                        interrupt_out_n_i,
  output logic                             interrupt_out_n_o,
  output logic                             interrupt_out_n_oe,
  output logic                             reset_out_n,
  output logic                             fail_output,
  output logic                             io_undervoltage,
  output logic                             buck_enable,
  output mode_select_field_pkg::mode_select_field_type       mode_state,
  output logic [1:0]                       mode_select_field,
  output logic                             fail_count_state,
  output logic                             strap_pullup_state,
  output logic                             development_mode,
  output logic                             por_flag,
  output logic                             wake_event_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain: frame receiver

  logic [1:0]  link_rst_sync;
  logic        link_rst;
  logic [3:0]  bit_cnt;
  logic [14:0] shift;
  logic [15:0] frame;
  logic        frame_tgl;

  always_ff @(posedge spi_clk) begin
    link_rst_sync <= {link_rst_sync[0], rst};
  end
  assign link_rst = link_rst_sync[1];

  always_ff @(posedge spi_clk) begin
    if (link_rst) begin
      bit_cnt   <= 4'h0;
      shift     <= 15'h0000;
      frame     <= 16'h0000;
      frame_tgl <= 1'b0;
    end else if (spi_cs_n) begin
      bit_cnt <= 4'h0;
    end else begin
      shift   <= {shift[13:0], spi_mosi};
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt == 4'hF) begin
        frame     <= {shift, spi_mosi};
        frame_tgl <= ~frame_tgl;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core domain: synchronisers and frame decode

  localparam int NP = mode_select_field_pkg::PIN_COUNT;

  logic [NP-1:0] pin_raw;
  logic [NP-1:0] pin_meta;
  logic [NP-1:0] pin;
  logic [2:0]    tgl_sync;
  logic          frame_evt;
  logic          is_wr;
  logic [6:0]    addr;
  logic [7:0]    wdata;
  logic          mode_wr;
  logic          hw_wr;
  logic          wd_wr;
  logic          io_ok;

  assign pin_raw = {thermal_shutdown_two, interrupt_out_n_i, test_pin,
                    wake_in, io_overvoltage, vs_above_short, io_supply_ok};

  // no reset: pins settle while rst is held; a reset value
  // would look like a low test pin for two cycles after release
  always_ff @(posedge core_clk) begin
    pin_meta <= pin_raw;
    pin      <= pin_meta;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tgl_sync <= 3'h0;
    end else begin
      tgl_sync <= {tgl_sync[1:0], frame_tgl};
    end
  end

  // frame word is held in the link domain until the next frame ends
  assign frame_evt = tgl_sync[2] ^ tgl_sync[1];
  assign is_wr     = frame[mode_select_field_pkg::WRITE_BIT];
  assign addr      = frame[6:0];
  assign wdata     = frame[15:mode_select_field_pkg::DATA_LSB];
  assign mode_wr   = frame_evt & is_wr & (addr == mode_select_field_pkg::MODE_CTRL_ADDR);
  assign hw_wr     = frame_evt & is_wr & (addr == mode_select_field_pkg::HW_CTRL_ADDR);
  assign wd_wr     = frame_evt & is_wr & (addr == mode_select_field_pkg::WATCHDOG_CONTROL_REG_ADDR);
  assign io_ok     = pin[mode_select_field_pkg::PIN_IO_OK];

  ////////////////////////////////////////////////////////////////////////////
  // control bits

  logic ov_rst_en;
  logic limit_three;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fail_count_state <= mode_select_field_pkg::FAIL_CNT_RESET;
      ov_rst_en        <= mode_select_field_pkg::OV_RST_RESET;
      limit_three      <= 1'b0;
    end else begin
      if (hw_wr) begin
        fail_count_state <= wdata[mode_select_field_pkg::HW_FAIL_CNT_BIT];
        ov_rst_en        <= wdata[mode_select_field_pkg::HW_OV_RST_BIT];
      end
      if (wd_wr) begin
        limit_three <= wdata[mode_select_field_pkg::WD_LIMIT3_BIT];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      por_flag <= 1'b1;
    end else if (hw_wr && wdata[mode_select_field_pkg::HW_POR_CLR_BIT]) begin
      por_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog

  logic [mode_select_field_pkg::WD_CNT_W-1:0] wd_cnt;
  logic [1:0]                        wd_fails;
  logic [1:0]                        wd_resets;
  logic                              wd_run;
  logic                              wd_fail;

  assign wd_run  = reset_out_n & ~development_mode &
                   (mode_state == mode_select_field_pkg::MODE_INIT ||
                    mode_state == mode_select_field_pkg::MODE_NORMAL ||
                    mode_state == mode_select_field_pkg::MODE_STOP);
  assign wd_fail = wd_run & ~wd_wr &
                   (wd_cnt == mode_select_field_pkg::WD_CNT_W'(LONG_WINDOW_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (rst || !wd_run || wd_wr || wd_fail) begin
      wd_cnt <= '0;
    end else begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || wd_wr) begin
      wd_fails  <= 2'h0;
      wd_resets <= 2'h0;
    end else if (wd_fail) begin
      if (wd_fails != mode_select_field_pkg::WD_FAIL_SAT) begin
        wd_fails <= wd_fails + 2'h1;
      end
      if (strap_pullup_state && wd_resets != mode_select_field_pkg::MAX_WD_RESETS) begin
        wd_resets <= wd_resets + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // failure reactions

  logic second_fail;
  logic fail_hard;
  logic wd_to_fs;
  logic wd_to_rs;
  logic ov_evt;
  logic fail_set;
  logic fail_act;

  assign second_fail = wd_fails != 2'h0;
  assign fail_hard   = fail_count_state | second_fail;
  assign wd_to_fs    = wd_fail & ~strap_pullup_state & fail_hard;
  assign wd_to_rs    = wd_fail & ~wd_to_fs &
                       ~(strap_pullup_state & limit_three &
                         wd_resets == mode_select_field_pkg::MAX_WD_RESETS);
  assign ov_evt      = ov_rst_en & pin[mode_select_field_pkg::PIN_IO_OV] &
                       (mode_state == mode_select_field_pkg::MODE_NORMAL ||
                        mode_state == mode_select_field_pkg::MODE_STOP);
  assign fail_set    = (wd_fail & fail_hard) | ov_evt |
                       (mode_state == mode_select_field_pkg::MODE_FAILSAFE);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fail_act <= 1'b0;
    end else if (fail_set) begin
      fail_act <= 1'b1;
    end
  end

  // supplies not yet up: nothing reported
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fail_output     <= 1'b0;
      io_undervoltage <= 1'b0;
    end else begin
      fail_output     <= fail_act & (io_ok | pin[mode_select_field_pkg::PIN_VS_SHORT]);
      io_undervoltage <= ~io_ok & pin[mode_select_field_pkg::PIN_VS_SHORT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode state machine

  mode_select_field_pkg::mode_select_field_type next_mode;
  logic [mode_select_field_pkg::RD_CNT_W-1:0] rd_cnt;
  logic                              rd_done;
  logic                              wake;

  assign wake    = pin[mode_select_field_pkg::PIN_WAKE];
  assign rd_done = ~reset_out_n & io_ok &
                   (rd_cnt == mode_select_field_pkg::RD_CNT_W'(mode_select_field_pkg::RESET_DELAY_CYC - 1));

  always_comb begin
    next_mode = mode_state;
    case (mode_state)
      mode_select_field_pkg::MODE_INIT: begin
        if (frame_evt) begin
          next_mode = mode_select_field_pkg::MODE_NORMAL;
        end
      end
      mode_select_field_pkg::MODE_NORMAL: begin
        if (mode_wr) begin
          case (wdata[1:0])
            mode_select_field_pkg::MSEL_SLEEP:    next_mode = mode_select_field_pkg::MODE_SLEEP;
            mode_select_field_pkg::MSEL_STOP:     next_mode = mode_select_field_pkg::MODE_STOP;
            mode_select_field_pkg::MSEL_SOFT_RST: next_mode = mode_select_field_pkg::MODE_INIT;
            default:                     next_mode = mode_select_field_pkg::MODE_NORMAL;
          endcase
        end
      end
      mode_select_field_pkg::MODE_STOP: begin
        if (mode_wr) begin
          case (wdata[1:0])
            mode_select_field_pkg::MSEL_SLEEP:    next_mode = mode_select_field_pkg::MODE_RESTART;
            mode_select_field_pkg::MSEL_SOFT_RST: next_mode = mode_select_field_pkg::MODE_INIT;
            default:                     next_mode = mode_select_field_pkg::MODE_NORMAL;
          endcase
        end
      end
      mode_select_field_pkg::MODE_SLEEP, mode_select_field_pkg::MODE_FAILSAFE: begin
        if (wake) begin
          next_mode = mode_select_field_pkg::MODE_RESTART;
        end
      end
      mode_select_field_pkg::MODE_RESTART: begin
        if (rd_done) begin
          next_mode = mode_select_field_pkg::MODE_NORMAL;
        end
      end
      default: begin
        next_mode = mode_select_field_pkg::MODE_INIT;
      end
    endcase
    if ((mode_state == mode_select_field_pkg::MODE_NORMAL ||
         mode_state == mode_select_field_pkg::MODE_STOP) && !io_ok) begin
      next_mode = mode_select_field_pkg::MODE_RESTART;
    end
    if (wd_to_rs || (ov_evt && strap_pullup_state)) begin
      next_mode = mode_select_field_pkg::MODE_RESTART;
    end
    if (wd_to_fs || (ov_evt && !strap_pullup_state)) begin
      next_mode = mode_select_field_pkg::MODE_FAILSAFE;
    end
    if (pin[mode_select_field_pkg::PIN_TSD]) begin
      next_mode = mode_select_field_pkg::MODE_FAILSAFE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_state  <= mode_select_field_pkg::MODE_INIT;
      buck_enable <= 1'b1;
    end else begin
      mode_state  <= next_mode;
      buck_enable <= next_mode != mode_select_field_pkg::MODE_SLEEP &&
                     next_mode != mode_select_field_pkg::MODE_FAILSAFE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_select_field <= mode_select_field_pkg::MSEL_RESET_VAL;
    end else if (next_mode == mode_select_field_pkg::MODE_RESTART) begin
      mode_select_field <= mode_select_field_pkg::MSEL_NORMAL;
    end else if (mode_wr) begin
      mode_select_field <= wdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset output and delay

  logic hold_low;

  assign hold_low = !io_ok ||
                    next_mode == mode_select_field_pkg::MODE_SLEEP ||
                    next_mode == mode_select_field_pkg::MODE_FAILSAFE ||
                    (next_mode == mode_select_field_pkg::MODE_RESTART &&
                     mode_state != mode_select_field_pkg::MODE_RESTART);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reset_out_n <= 1'b0;
      rd_cnt      <= '0;
    end else if (hold_low) begin
      reset_out_n <= 1'b0;
      rd_cnt      <= '0;
    end else if (rd_done) begin
      reset_out_n <= 1'b1;
    end else if (!reset_out_n && (mode_state == mode_select_field_pkg::MODE_INIT ||
                                  mode_state == mode_select_field_pkg::MODE_RESTART)) begin
      rd_cnt <= rd_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap latch, development mode, wake flag

  logic [mode_select_field_pkg::FILT_CNT_W-1:0] filt_cnt;
  logic                                filt_done;
  logic                                filt_hit;

  assign filt_hit = reset_out_n & ~filt_done &
                    (filt_cnt == mode_select_field_pkg::FILT_CNT_W'(mode_select_field_pkg::CFG_FILT_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (rst || !reset_out_n) begin
      filt_cnt  <= '0;
      filt_done <= 1'b0;
    end else if (filt_hit) begin
      filt_done <= 1'b1;
    end else if (!filt_done) begin
      filt_cnt <= filt_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      strap_pullup_state <= 1'b0;
    end else if (filt_hit && por_flag) begin
      strap_pullup_state <= pin[mode_select_field_pkg::PIN_INTR];
    end
  end

  // weak pull-down from threshold crossing to filtered release
  always_ff @(posedge core_clk) begin
    if (rst) begin
      interrupt_out_n_oe <= 1'b0;
    end else begin
      interrupt_out_n_oe <= por_flag & io_ok &
                            (~reset_out_n | ~filt_done);
    end
  end
  assign interrupt_out_n_o = 1'b0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      development_mode <= 1'b0;
    end else if (mode_state == mode_select_field_pkg::MODE_INIT &&
                 !pin[mode_select_field_pkg::PIN_TEST]) begin
      development_mode <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake_event_flag <= 1'b0;
    end else if (wake && mode_state != mode_select_field_pkg::MODE_INIT) begin
      wake_event_flag <= 1'b1;
    end else if (mode_wr) begin
      wake_event_flag <= 1'b0;
    end
  end

endmodule // mode_select_field_ctrl

`default_nettype wire

// ==== test/mode_select_field_ctrl_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none

module mode_select_field_ctrl_asserts #(
  parameter int unsigned LONG_WINDOW_CYC = 2000
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       io_supply_ok,
  input  wire logic                       vs_above_short,
  input  wire logic                       io_overvoltage,
  input  wire logic                       thermal_shutdown_two,
  input  wire logic                       interrupt_out_n_oe,
  input  wire logic                       reset_out_n,
  input  wire logic                       fail_output,
  input  wire logic                       io_undervoltage,
  input  wire logic                       buck_enable,
  input  wire mode_select_field_pkg::mode_select_field_type mode_state,
  input  wire logic [1:0]                 mode_select_field,
  input  wire logic                       strap_pullup_state,
  input  wire logic                       development_mode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // cycles with io supply up, cycles since reset output release
  logic [10:0] io_cnt;
  logic [7:0]  up_cnt;

  always_ff @(posedge core_clk) begin
    if (rst || !io_supply_ok) io_cnt <= 11'h000;
    else if (io_cnt != 11'h7FF) io_cnt <= io_cnt + 11'h001;
  end

  always_ff @(posedge core_clk) begin
    if (rst || !reset_out_n) up_cnt <= 8'h00;
    else if (up_cnt != 8'hFF) up_cnt <= up_cnt + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_low_power_buck: assert property ((mode_state inside
    {mode_select_field_pkg::MODE_SLEEP, mode_select_field_pkg::MODE_FAILSAFE})[*2]
    |-> !buck_enable) else $error("buck on in low power mode");
  a_stop_buck_on: assert property (
    (mode_state == mode_select_field_pkg::MODE_STOP)[*2] |-> buck_enable)
    else $error("buck off in stop mode");
  a_restart_clears_sel: assert property (
    (mode_state == mode_select_field_pkg::MODE_RESTART)[*2]
    |-> mode_select_field == mode_select_field_pkg::MSEL_RESET_VAL)
    else $error("mode select not cleared in restart");
  a_restart_release: assert property (
    mode_state == mode_select_field_pkg::MODE_RESTART
    ##1 mode_state == mode_select_field_pkg::MODE_NORMAL |-> reset_out_n)
    else $error("reset output low on entry to normal");
  a_hold_reset_low: assert property (
    (!io_supply_ok)[*4] |-> !reset_out_n)
    else $error("reset output high without io supply");
  a_release_delay: assert property (
    $rose(reset_out_n) |-> int'(io_cnt) >= mode_select_field_pkg::RESET_DELAY_CYC)
    else $error("reset output released too early");
  a_no_early_fail: assert property (
    (!io_supply_ok && !vs_above_short)[*4]
    |-> !fail_output && !io_undervoltage)
    else $error("fail or undervoltage before supplies");
  a_strap_at_edge: assert property (
    $changed(strap_pullup_state)
    |-> reset_out_n && up_cnt inside {[8'h28:8'h3C]})
    else $error("strap changed away from reset edge");
  a_pulldown_window: assert property (
    interrupt_out_n_oe |-> !reset_out_n || up_cnt <= 8'h3C)
    else $error("pull-down active outside reset delay");
  a_dev_no_reset: assert property ((development_mode
    && mode_state == mode_select_field_pkg::MODE_NORMAL && io_supply_ok
    && !io_overvoltage && !thermal_shutdown_two)[*4]
    |=> mode_state != mode_select_field_pkg::MODE_RESTART)
    else $error("restart while in development mode");

endmodule // mode_select_field_ctrl_asserts

bind mode_select_field_ctrl mode_select_field_ctrl_asserts #(
  .LONG_WINDOW_CYC(LONG_WINDOW_CYC)
) chk_u (
  .core_clk, .rst, .io_supply_ok, .vs_above_short, .io_overvoltage,
  .thermal_shutdown_two, .interrupt_out_n_oe, .reset_out_n, .fail_output,
  .io_undervoltage, .buck_enable, .mode_state, .mode_select_field,
  .strap_pullup_state, .development_mode
);

`default_nettype wire

// ==== test/mcu_link_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module mcu_link_model (
  input  wire logic rst,
  output wire logic spi_clk,
  output var logic  spi_cs_n,
  output var logic  spi_mosi
);
  logic free_clk = 1'b0;
  logic run      = 1'b0;
  logic hold     = 1'b0;

  initial spi_cs_n = 1'b1;
  initial spi_mosi = 1'b0;

  initial begin
    #17;
    forever #62.5 free_clk = ~free_clk;
  end

  // clock stands still outside frames and reset
  always @(negedge free_clk) hold <= rst;
  assign spi_clk = free_clk & (run | hold);

  // idle edges before and after each frame
  task automatic send(input logic [15:0] frame);
    @(negedge free_clk);
    run = 1'b1;
    repeat (3) @(negedge free_clk);
    for (int i = 15; i >= 0; i--) begin
      spi_cs_n = 1'b0;
      spi_mosi = frame[i];
      @(negedge free_clk);
    end
    spi_cs_n = 1'b1;
    spi_mosi = ~frame[0];
    @(negedge free_clk);
    run = 1'b0;
  endtask

endmodule // mcu_link_model

`default_nettype wire

// ==== test/tb_mode_select_field_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_mode_select_field_ctrl;
  localparam int WIN = 2000;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       io_supply_ok = 1'b0;
  logic       vs_above_short = 1'b0;
  logic       io_overvoltage = 1'b0;
  logic       wake_in = 1'b0;
  logic       test_pin = 1'b1;
  logic       strap_pu = 1'b0;
  wire        intr_pin;
  wire        spi_clk;
  wire        spi_cs_n;
  wire        spi_mosi;
  logic       interrupt_out_n_o, interrupt_out_n_oe, reset_out_n;
  logic       fail_output, io_undervoltage, buck_enable, por_flag;
  logic [1:0] mode_select_field;
  logic       fail_count_state, strap_pullup_state, development_mode;
  logic       wake_event_flag;
  int         failures = 0;
  int         checks = 0;
  int         cyc = 0;
  mode_select_field_pkg::mode_select_field_type mode_state;

  always #5 core_clk = ~core_clk;

  // external pull-up wins over the weak pull-down
  assign intr_pin = interrupt_out_n_oe ? (strap_pu | interrupt_out_n_o)
                                       : strap_pu;

  mcu_link_model mcu_u (.rst, .spi_clk, .spi_cs_n, .spi_mosi);

  mode_select_field_ctrl #(.LONG_WINDOW_CYC(WIN)) dut_u (
    .core_clk, .rst, .spi_clk, .spi_cs_n, .spi_mosi, .io_supply_ok,
    .vs_above_short, .io_overvoltage, .wake_in, .test_pin,
    .thermal_shutdown_two(1'b0), .interrupt_out_n_i(intr_pin),
    .interrupt_out_n_o, .interrupt_out_n_oe, .reset_out_n, .fail_output,
    .io_undervoltage, .buck_enable, .mode_state, .mode_select_field,
    .fail_count_state, .strap_pullup_state, .development_mode, .por_flag,
    .wake_event_flag
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [3:0] exp,
                       input logic [3:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    mcu_u.send({d, 1'b1, a});
    repeat (4) @(negedge core_clk);
  endtask

  task automatic wait_mode(input mode_select_field_pkg::mode_select_field_type m, int lim);
    int n;
    n = 0;
    while (mode_state !== m && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    repeat (2) @(negedge core_clk);
    check("mode_state", m, mode_state);
  endtask

  // link domain needs spi edges inside reset
  task automatic power_up(input logic pu, input logic tp);
    int n;
    @(posedge core_clk);
    rst <= 1'b1;
    io_supply_ok <= 1'b0;
    vs_above_short <= 1'b0;
    strap_pu <= pu;
    test_pin <= tp;
    repeat (60) @(posedge core_clk);
    rst <= 1'b0;
    repeat (20) @(negedge core_clk);
    check("reset_out_n", 0, reset_out_n);
    check("fail_or_uv", 0, fail_output | io_undervoltage);
    check("mode_state", mode_select_field_pkg::MODE_INIT, mode_state);
    @(posedge core_clk);
    vs_above_short <= 1'b1;
    repeat (5) @(negedge core_clk);
    check("io_undervoltage", 1, io_undervoltage);
    @(posedge core_clk);
    io_supply_ok <= 1'b1;
    n = 0;
    while (reset_out_n !== 1'b1 && n < 1100) begin
      @(negedge core_clk);
      n++;
    end
    check("release_delay", 1, n >= 1000 && n < 1100);
    repeat (60) @(negedge core_clk);
    check("strap_pullup_state", pu, strap_pullup_state);
    check("interrupt_out_n_oe", 0, interrupt_out_n_oe);
  endtask

  task automatic cfg4_watchdog();
    power_up(1'b0, 1'b1);
    @(posedge core_clk) wake_in <= 1'b1;
    repeat (5) @(posedge core_clk);
    wake_in <= 1'b0;
    repeat (4) @(negedge core_clk);
    check("wake_event_flag", 0, wake_event_flag);
    wr(mode_select_field_pkg::WATCHDOG_CONTROL_REG_ADDR, 8'h00);
    check("mode_state", mode_select_field_pkg::MODE_NORMAL, mode_state);
    wr(mode_select_field_pkg::MODE_CTRL_ADDR, 8'h02);
    check("mode_select_field", 2, mode_select_field);
    check("mode_state", mode_select_field_pkg::MODE_STOP, mode_state);
    wait_mode(mode_select_field_pkg::MODE_RESTART, WIN + 100);
    check("fail_output", 0, fail_output);
    check("mode_select_field", 0, mode_select_field);
    wait_mode(mode_select_field_pkg::MODE_NORMAL, 1100);
    check("reset_out_n", 1, reset_out_n);
    wait_mode(mode_select_field_pkg::MODE_FAILSAFE, WIN + 100);
    check("fail_output", 1, fail_output);
    check("buck_enable", 0, buck_enable);
  endtask

  task automatic cfg1_dev_overvoltage();
    power_up(1'b1, 1'b0);
    check("development_mode", 1, development_mode);
    wr(7'h7F, 8'h00);
    check("mode_state", mode_select_field_pkg::MODE_NORMAL, mode_state);
    wr(mode_select_field_pkg::HW_CTRL_ADDR, 8'h07);
    check("fail_count_state", 1, fail_count_state);
    check("por_flag", 0, por_flag);
    repeat (WIN + 500) @(negedge core_clk);
    check("mode_state", mode_select_field_pkg::MODE_NORMAL, mode_state);
    @(posedge core_clk);
    strap_pu <= 1'b0;
    io_overvoltage <= 1'b1;
    wait_mode(mode_select_field_pkg::MODE_RESTART, 20);
    check("fail_output", 1, fail_output);
    @(posedge core_clk) io_overvoltage <= 1'b0;
    wait_mode(mode_select_field_pkg::MODE_NORMAL, 1100);
    repeat (60) @(negedge core_clk);
    check("strap_pullup_state", 1, strap_pullup_state);
  endtask

  task automatic fail_count_select_bit_failsafe();
    power_up(1'b0, 1'b1);
    wr(mode_select_field_pkg::HW_CTRL_ADDR, 8'h04);
    wait_mode(mode_select_field_pkg::MODE_FAILSAFE, WIN + 100);
    check("fail_output", 1, fail_output);
    @(posedge core_clk) wake_in <= 1'b1;
    wait_mode(mode_select_field_pkg::MODE_RESTART, 20);
    check("wake_event_flag", 1, wake_event_flag);
    @(posedge core_clk) wake_in <= 1'b0;
    wait_mode(mode_select_field_pkg::MODE_NORMAL, 1100);
    wr(mode_select_field_pkg::MODE_CTRL_ADDR, 8'h01);
    check("mode_state", mode_select_field_pkg::MODE_SLEEP, mode_state);
    check("buck_enable", 0, buck_enable);
    check("reset_out_n", 0, reset_out_n);
  endtask

  task automatic cfg3_limit();
    power_up(1'b1, 1'b1);
    wr(mode_select_field_pkg::WATCHDOG_CONTROL_REG_ADDR, 8'h01);
    repeat (3) begin
      wait_mode(mode_select_field_pkg::MODE_RESTART, WIN + 100);
      wait_mode(mode_select_field_pkg::MODE_NORMAL, 1100);
    end
    check("fail_output", 1, fail_output);
    repeat (WIN + 200) @(negedge core_clk);
    check("reset_out_n", 1, reset_out_n);
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    cfg4_watchdog();
    cfg1_dev_overvoltage();
    fail_count_select_bit_failsafe();
    cfg3_limit();
    summarize();
  end

endmodule // tb_mode_select_field_ctrl

`default_nettype wire
